// ### bench/hmtc_trap_csr_test.sv
// Self-checking bench for the machine trap and privilege control block.
module hmtc_trap_csr_test
  import hmtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, reg_we, reg_re, sgei_pin, trap_take, trap_gpf, trap_gpa_valid;
  logic ret_take, guest_access, eff_virt, eff_translate, eff_two_stage, eff_user_permit;
  logic eff_mxr_any, eff_mxr_guest, cur_virt;
  logic [1:0] eff_priv, cur_priv;
  logic [3:0] reg_addr;
  logic [XLEN-1:0] reg_wdata, reg_rdata, trap_gpa, trap_value, trap_instr, d, s;
  logic [8:0] regime [6] = '{9'h018, 9'h102, 9'h12A, 9'h1F8, 9'h187, 9'h1AF};
  int errors = 0;
  int tests_run = 0;

  hmtc_trap_csr dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sgei_pin(sgei_pin),
    .trap_take(trap_take), .trap_gpf(trap_gpf), .trap_gpa_valid(trap_gpa_valid),
    .trap_gpa(trap_gpa), .trap_value(trap_value), .trap_instr(trap_instr),
    .ret_take(ret_take), .guest_access(guest_access), .eff_priv(eff_priv),
    .eff_virt(eff_virt), .eff_translate(eff_translate), .eff_two_stage(eff_two_stage),
    .eff_user_permit(eff_user_permit), .eff_mxr_any(eff_mxr_any),
    .eff_mxr_guest(eff_mxr_guest), .cur_priv(cur_priv), .cur_virt(cur_virt));

  // Free-running hart clock, 4 ns period.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [63:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [3:0] a, output logic [63:0] v);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rdchk(input string n, input logic [3:0] a, input logic [63:0] exp);
    logic [63:0] v;
    rd(a, v);
    chk(n, v, exp);
  endtask

  task automatic trap(input logic gpf, input logic gv, input logic [63:0] g);
    @(posedge clk);
    trap_take <= 1'b1;
    trap_gpf <= gpf;
    trap_gpa_valid <= gv;
    trap_gpa <= g;
    trap_value <= ~g;
    trap_instr <= g ^ 64'h00000000FFFF0000;
    @(posedge clk);
    trap_take <= 1'b0;
    #1;
  endtask

  task automatic ret();
    @(posedge clk);
    ret_take <= 1'b1;
    @(posedge clk);
    ret_take <= 1'b0;
    #1;
  endtask

  // The effective regime lands one cycle after the state that selects it.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog so a hung sequence still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  // Main sequence of tests.
  initial
  begin
    rst = 1'b1;
    {reg_we, reg_re, sgei_pin, trap_take, trap_gpf, trap_gpa_valid, ret_take} = 7'h00;
    guest_access = 1'b0;
    reg_addr = 4'h0;
    {reg_wdata, trap_gpa, trap_value, trap_instr} = {4{64'h0}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("cur_priv", {62'h0, cur_priv}, 64'h3);
    chk("cur_virt", {63'h0, cur_virt}, 64'h0);
    rdchk("mdeleg rst", A_MDELEG, 64'h1444);
    $display("reset test done");
    wr(A_MDELEG, 64'hFFFF);
    rdchk("mdeleg ones", A_MDELEG, 64'h1666);
    wr(A_HDELEG, 64'hFFFF);
    rd(A_HDELEG, d);
    chk("hdeleg wide", d & ~64'h1666, 64'h0);
    wr(A_MDELEG, 64'h0);
    rdchk("mdeleg zero", A_MDELEG, 64'h1444);
    rd(A_HDELEG, d);
    chk("hdeleg narrow", d & ~64'h1444, 64'h0);
    wr(A_MIP, 64'h0666);
    rdchk("hip alias", A_HIP, 64'h0444);
    wr(A_HIP, 64'h0);
    rdchk("mip alias", A_MIP, 64'h0222);
    @(posedge clk);
    sgei_pin <= 1'b1;
    d = 64'h0;
    for (int i = 0; i < 8 && d[B_SGEI] !== 1'b1; i++)
      rd(A_MIP, d);
    chk("mip sgei", d, 64'h1222);
    rdchk("hip sgei", A_HIP, 64'h1000);
    wr(A_MIE, 64'h1EEE);
    rdchk("hie alias", A_HIE, 64'h1444);
    wr(A_HIE, 64'h0);
    rdchk("mie alias", A_MIE, 64'h0AAA);
    $display("interrupt test done");
    wr(A_GSTATUS, 64'h00000000000C0000);
    foreach (regime[i])
    begin
      s = 64'h0;
      s[B_MODIFY_PRIVILEGE_BIT] = regime[i][8];
      s[B_MPV] = regime[i][7];
      s[B_MPP_LO+:2] = regime[i][6:5];
      s[B_MXR] = 1'b1;
      wr(A_STATUS, s);
      settle();
      chk("eff_priv", {62'h0, eff_priv}, {62'h0, regime[i][4:3]});
      chk("eff_virt", {63'h0, eff_virt}, {63'h0, regime[i][2]});
      chk("eff_tr", {63'h0, eff_translate}, {63'h0, regime[i][1]});
      chk("eff_two", {63'h0, eff_two_stage}, {63'h0, regime[i][0]});
      chk("eff_sum", {63'h0, eff_user_permit}, {63'h0, regime[i][0]});
      chk("mxr_any", {63'h0, eff_mxr_any}, 64'h1);
      chk("mxr_g", {63'h0, eff_mxr_guest}, {63'h0, regime[i][0]});
    end
    wr(A_STATUS, 64'h0000000000021800);
    wr(A_HSTATUS, 64'h0100);
    guest_access <= 1'b1;
    settle();
    chk("ga priv", {60'h0, eff_priv, eff_virt, eff_two_stage}, 64'h7);
    chk("ga sum", {63'h0, eff_user_permit}, 64'h1);
    chk("mxr off", {63'h0, eff_mxr_any}, 64'h0);
    wr(A_HSTATUS, 64'h0);
    settle();
    chk("ga user", {60'h0, eff_priv, eff_virt, eff_two_stage}, 64'h3);
    @(posedge clk);
    guest_access <= 1'b0;
    $display("regime test done");
    wr(A_STATUS, 64'h0000008000000800);
    ret();
    chk("ret virt", {61'h0, cur_virt, cur_priv}, 64'h5);
    trap(1'b1, 1'b1, 64'h0123456789ABCDEF);
    chk("trap mode", {61'h0, cur_virt, cur_priv}, 64'h3);
    rd(A_STATUS, d);
    chk("prev mode", {62'h0, d[B_MPV], d[B_MPP_LO+1]}, 64'h2);
    chk("prev low", {63'h0, d[B_MPP_LO]}, 64'h1);
    rdchk("tval", A_TVAL, ~64'h0123456789ABCDEF);
    rdchk("tval2 gpf", A_TVAL2, 64'h0123456789ABCDEF >> 2);
    rdchk("tinst", A_TINST, 64'h012345677654CDEF);
    trap(1'b0, 1'b1, 64'h00000000000ABCD0);
    rdchk("tval2 other", A_TVAL2, 64'h0);
    rdchk("tinst 2", A_TINST, 64'h00000000FFF5BCD0);
    trap(1'b1, 1'b0, 64'h0000000000001234);
    rdchk("tval2 none", A_TVAL2, 64'h0);
    rdchk("tval 3", A_TVAL, ~64'h0000000000001234);
    wr(A_STATUS, 64'h0000008000001800);
    ret();
    chk("ret mach", {61'h0, cur_virt, cur_priv}, 64'h3);
    $display("trap test done");
    wr(A_TVAL2, 64'hA5A5F0F012345678);
    rdchk("tval2 warl", A_TVAL2, 64'hA5A5F0F012345678);
    wr(A_TINST, 64'h5A5A0F0F87654321);
    rdchk("tinst warl", A_TINST, 64'h5A5A0F0F87654321);
    wr(4'hF, 64'hFFFFFFFFFFFFFFFF);
    rdchk("unmapped", 4'hF, 64'h0);
    $display("register test done");
    close_out();
  end
endmodule // hmtc_trap_csr_test

// ### common/hmtc_pkg.sv
// Constants shared by the machine trap and privilege control logic.
package hmtc_pkg;
  localparam int XLEN = 64;
  localparam int IRQW = 16;
  localparam int GUEST_EXT_IRQ_COUNT = 4;
  // Register indexes on the plain register port.
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_GSTATUS = 4'h1;
  localparam logic [3:0] A_HSTATUS = 4'h2;
  localparam logic [3:0] A_MDELEG = 4'h3;
  localparam logic [3:0] A_HDELEG = 4'h4;
  localparam logic [3:0] A_MIP = 4'h5;
  localparam logic [3:0] A_MIE = 4'h6;
  localparam logic [3:0] A_HIP = 4'h7;
  localparam logic [3:0] A_HIE = 4'h8;
  localparam logic [3:0] A_TVAL = 4'h9;
  localparam logic [3:0] A_TVAL2 = 4'hA;
  localparam logic [3:0] A_TINST = 4'hB;
  localparam logic [3:0] A_PRIV = 4'hC;
  // Field positions.
  localparam int B_MODIFY_PRIVILEGE_BIT = 17;
  localparam int B_SUM = 18;
  localparam int B_MXR = 19;
  localparam int B_MPP_LO = 11;
  localparam int B_MPV = 39;
  localparam int B_HYP_GUEST_PRIV_BIT = 8;
  localparam int B_SGEI = 12;
  // Interrupt masks, reset values and privilege encodings.
  localparam logic [IRQW-1:0] DELEG_FORCED = 16'h0444;
  localparam logic [IRQW-1:0] DELEG_SGEI = 16'h1000;
  localparam logic [IRQW-1:0] DELEG_WMASK = 16'h0222;
  localparam logic [IRQW-1:0] GUEST_MASK = 16'h1444;
  localparam logic [IRQW-1:0] MIP_WMASK = 16'h0666;
  localparam logic [IRQW-1:0] HIP_WMASK = 16'h0444;
  localparam logic [IRQW-1:0] MIE_WMASK = 16'h1EEE;
  localparam logic [IRQW-1:0] IRQ_RESET = 16'h0000;
  localparam logic [XLEN-1:0] WORD_RESET = 64'h0000000000000000;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
endpackage

// ### logic/hmtc_trap_csr.sv
// Machine trap entry, return, delegation and effective-privilege logic.
//
// The strobed register port and the address map are this design's own decisions.
module hmtc_trap_csr
  import hmtc_pkg::*;
(
  input wire logic clk, // Hart clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [3:0] reg_addr, // Register index.
  input wire logic [XLEN-1:0] reg_wdata, // Write data.
  input wire logic reg_we, // Write strobe.
  input wire logic reg_re, // Read strobe.
  output logic [XLEN-1:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire logic sgei_pin, // Guest external interrupt level, asynchronous.
  input wire logic trap_take, // Trap into machine mode, one-cycle pulse.
  input wire logic trap_gpf, // The trap is a guest-page fault.
  input wire logic trap_gpa_valid, // A guest physical address is supplied.
  input wire logic [XLEN-1:0] trap_gpa, // Faulting guest physical address.
  input wire logic [XLEN-1:0] trap_value, // Value for the trap value register.
  input wire logic [XLEN-1:0] trap_instr, // Value for the trap instruction register.
  input wire logic ret_take, // Machine trap return executes, pulse.
  input wire logic guest_access, // Guest load, exec-load or store.
  output logic [1:0] eff_priv, // Effective privilege of explicit accesses.
  output logic eff_virt, // Effective virtualization mode.
  output logic eff_translate, // Address translation applies.
  output logic eff_two_stage, // Guest and host stages both apply.
  output logic eff_user_permit, // User-page access permit in force.
  output logic eff_mxr_any, // Any executable page is readable.
  output logic eff_mxr_guest, // Guest-stage executable readable if host allows.
  output logic [1:0] cur_priv, // Current privilege mode.
  output logic cur_virt // Current virtualization mode.
);

  logic [XLEN-1:0] status_reg, status_next;
  logic [XLEN-1:0] gstatus_reg, gstatus_next;
  logic [XLEN-1:0] hstatus_reg, hstatus_next;
  logic [IRQW-1:0] mdeleg_reg, mdeleg_next;
  logic [IRQW-1:0] hdeleg_reg, hdeleg_next;
  logic [IRQW-1:0] ip_reg, ip_next;
  logic [IRQW-1:0] ie_reg, ie_next;
  logic [XLEN-1:0] tval_reg, tval_next;
  logic [XLEN-1:0] tval2_reg, tval2_next;
  logic [XLEN-1:0] tinst_reg, tinst_next;
  logic [1:0] priv_reg, priv_next;
  logic virt_reg, virt_next;
  logic [XLEN-1:0] rdata_reg, rdata_next;
  logic sgei_meta_reg, sgei_sync_reg;
  logic [1:0] eff_priv_reg, eff_priv_next;
  logic eff_virt_reg, eff_virt_next;
  logic eff_tr_reg, eff_tr_next;
  logic eff_two_reg, eff_two_next;
  logic eff_sum_reg, eff_sum_next;
  logic eff_mxa_reg, eff_mxa_next;
  logic eff_mxg_reg, eff_mxg_next;
  logic [IRQW-1:0] deleg_rd, hdeleg_rd, hip_rd, hie_rd, wlo;
  logic modify_privilege_bit, prev_virt_mode_bit;
  logic [1:0] prev_priv_field;

  assign modify_privilege_bit = status_reg[B_MODIFY_PRIVILEGE_BIT];
  assign prev_virt_mode_bit = status_reg[B_MPV];
  assign prev_priv_field = status_reg[B_MPP_LO+1:B_MPP_LO];
  assign wlo = reg_wdata[IRQW-1:0];

  // Read views of delegation and the hypervisor aliases.
  always_comb
  begin
    deleg_rd = (mdeleg_reg & DELEG_WMASK) | DELEG_FORCED;
    if (GUEST_EXT_IRQ_COUNT != 0)
    begin
      deleg_rd = deleg_rd | DELEG_SGEI;
    end
    hdeleg_rd = hdeleg_reg & deleg_rd;
    hip_rd = ip_reg & GUEST_MASK & deleg_rd;
    hie_rd = ie_reg & GUEST_MASK & deleg_rd;
  end

  // The pin level crosses in through two flops; only the second is read.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sgei_meta_reg <= 1'b0;
      sgei_sync_reg <= 1'b0;
    end
    else
    begin
      sgei_meta_reg <= sgei_pin;
      sgei_sync_reg <= sgei_meta_reg;
    end
  end

  // Next values of the control and trap registers; trap entry beats a write.
  always_comb
  begin
    status_next = status_reg;
    gstatus_next = gstatus_reg;
    hstatus_next = hstatus_reg;
    mdeleg_next = mdeleg_reg;
    hdeleg_next = hdeleg_reg;
    ip_next = ip_reg;
    ie_next = ie_reg;
    tval_next = tval_reg;
    tval2_next = tval2_reg;
    tinst_next = tinst_reg;
    priv_next = priv_reg;
    virt_next = virt_reg;
    if (reg_we)
    begin
      unique case (reg_addr)
        A_STATUS:
        begin
          status_next[B_MODIFY_PRIVILEGE_BIT] = reg_wdata[B_MODIFY_PRIVILEGE_BIT];
          status_next[B_SUM] = reg_wdata[B_SUM];
          status_next[B_MXR] = reg_wdata[B_MXR];
          status_next[B_MPV] = reg_wdata[B_MPV];
          // The reserved privilege encoding is not legal, so it is dropped.
          if (reg_wdata[B_MPP_LO+1:B_MPP_LO] != 2'h2)
          begin
            status_next[B_MPP_LO+1:B_MPP_LO] = reg_wdata[B_MPP_LO+1:B_MPP_LO];
          end
        end
        A_GSTATUS:
        begin
          gstatus_next[B_SUM] = reg_wdata[B_SUM];
          gstatus_next[B_MXR] = reg_wdata[B_MXR];
        end
        A_HSTATUS: hstatus_next[B_HYP_GUEST_PRIV_BIT] = reg_wdata[B_HYP_GUEST_PRIV_BIT];
        A_MDELEG: mdeleg_next = wlo & DELEG_WMASK;
        A_HDELEG: hdeleg_next = wlo & deleg_rd;
        A_MIP: ip_next = (ip_reg & ~MIP_WMASK) | (wlo & MIP_WMASK);
        A_MIE: ie_next = wlo & MIE_WMASK;
        A_HIP: ip_next = (ip_reg & ~(HIP_WMASK & deleg_rd)) | (wlo & HIP_WMASK & deleg_rd);
        A_HIE: ie_next = (ie_reg & ~(GUEST_MASK & deleg_rd)) | (wlo & GUEST_MASK & deleg_rd);
        A_TVAL: tval_next = reg_wdata;
        A_TVAL2: tval2_next = reg_wdata;
        A_TINST: tinst_next = reg_wdata;
        default: ;
      endcase
    end
    // The guest external pending bit follows the synchronised pin.
    ip_next[B_SGEI] = (GUEST_EXT_IRQ_COUNT != 0) ? sgei_sync_reg : 1'b0;
    if (trap_take)
    begin
      tval_next = trap_value;
      tval2_next = WORD_RESET;
      if (trap_gpf && trap_gpa_valid)
      begin
        tval2_next = trap_gpa >> 2;
      end
      tinst_next = trap_instr;
      status_next[B_MPV] = virt_reg;
      status_next[B_MPP_LO+1:B_MPP_LO] = priv_reg;
      priv_next = PRIV_M;
      virt_next = 1'b0;
    end
    else if (ret_take)
    begin
      virt_next = (prev_priv_field == PRIV_M) ? 1'b0 : prev_virt_mode_bit;
      priv_next = prev_priv_field;
      status_next[B_MPP_LO+1:B_MPP_LO] = PRIV_U;
      status_next[B_MPV] = 1'b0;
      if (prev_priv_field != PRIV_M)
      begin
        status_next[B_MODIFY_PRIVILEGE_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_reg <= WORD_RESET;
      gstatus_reg <= WORD_RESET;
      hstatus_reg <= WORD_RESET;
      mdeleg_reg <= IRQ_RESET;
      hdeleg_reg <= IRQ_RESET;
      ip_reg <= IRQ_RESET;
      ie_reg <= IRQ_RESET;
      tval_reg <= WORD_RESET;
      tval2_reg <= WORD_RESET;
      tinst_reg <= WORD_RESET;
      priv_reg <= PRIV_M;
      virt_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      gstatus_reg <= gstatus_next;
      hstatus_reg <= hstatus_next;
      mdeleg_reg <= mdeleg_next;
      hdeleg_reg <= hdeleg_next;
      ip_reg <= ip_next;
      ie_reg <= ie_next;
      tval_reg <= tval_next;
      tval2_reg <= tval2_next;
      tinst_reg <= tinst_next;
      priv_reg <= priv_next;
      virt_reg <= virt_next;
    end
  end

  // Effective access regime; it reflects register state one cycle late.
  always_comb
  begin
    eff_priv_next = priv_reg;
    eff_virt_next = virt_reg;
    if (guest_access)
    begin
      eff_virt_next = 1'b1;
      eff_priv_next = hstatus_reg[B_HYP_GUEST_PRIV_BIT] ? PRIV_S : PRIV_U;
    end
    else if (modify_privilege_bit)
    begin
      eff_priv_next = prev_priv_field;
      eff_virt_next = (prev_priv_field == PRIV_M) ? 1'b0 : prev_virt_mode_bit;
    end
    eff_tr_next = (eff_priv_next != PRIV_M);
    eff_two_next = eff_virt_next && eff_tr_next;
    eff_sum_next = eff_two_next ? gstatus_reg[B_SUM] : status_reg[B_SUM];
    eff_mxa_next = status_reg[B_MXR];
    eff_mxg_next = eff_two_next && gstatus_reg[B_MXR];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eff_priv_reg <= PRIV_M;
      eff_virt_reg <= 1'b0;
      eff_tr_reg <= 1'b0;
      eff_two_reg <= 1'b0;
      eff_sum_reg <= 1'b0;
      eff_mxa_reg <= 1'b0;
      eff_mxg_reg <= 1'b0;
    end
    else
    begin
      eff_priv_reg <= eff_priv_next;
      eff_virt_reg <= eff_virt_next;
      eff_tr_reg <= eff_tr_next;
      eff_two_reg <= eff_two_next;
      eff_sum_reg <= eff_sum_next;
      eff_mxa_reg <= eff_mxa_next;
      eff_mxg_reg <= eff_mxg_next;
    end
  end

  // Read mux; unmapped indexes and cycles without a read give zero.
  always_comb
  begin
    rdata_next = WORD_RESET;
    if (reg_re)
    begin
      unique case (reg_addr)
        A_STATUS: rdata_next = status_reg;
        A_GSTATUS: rdata_next = gstatus_reg;
        A_HSTATUS: rdata_next = hstatus_reg;
        A_MDELEG: rdata_next[IRQW-1:0] = deleg_rd;
        A_HDELEG: rdata_next[IRQW-1:0] = hdeleg_rd;
        A_MIP: rdata_next[IRQW-1:0] = ip_reg;
        A_MIE: rdata_next[IRQW-1:0] = ie_reg;
        A_HIP: rdata_next[IRQW-1:0] = hip_rd;
        A_HIE: rdata_next[IRQW-1:0] = hie_rd;
        A_TVAL: rdata_next = tval_reg;
        A_TVAL2: rdata_next = tval2_reg;
        A_TINST: rdata_next = tinst_reg;
        A_PRIV: rdata_next[2:0] = {virt_reg, priv_reg};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= WORD_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign eff_priv = eff_priv_reg;
  assign eff_virt = eff_virt_reg;
  assign eff_translate = eff_tr_reg;
  assign eff_two_stage = eff_two_reg;
  assign eff_user_permit = eff_sum_reg;
  assign eff_mxr_any = eff_mxa_reg;
  assign eff_mxr_guest = eff_mxg_reg;
  assign cur_priv = priv_reg;
  assign cur_virt = virt_reg;

  // Checks on the regime selection, delegation read views and trap bookkeeping.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_modify_privilege_bit_off_mode: assert property (
    !modify_privilege_bit && !guest_access |=> eff_priv == $past(priv_reg) && eff_virt == $past(virt_reg))
    else $error("current mode not used with modify-privilege clear");
  chk_machine_no_xlat: assert property (
    modify_privilege_bit && prev_priv_field == PRIV_M && !guest_access |=> !eff_translate && !eff_virt)
    else $error("machine regime translated");
  chk_virt_two_stage: assert property (
    modify_privilege_bit && prev_virt_mode_bit && prev_priv_field == PRIV_U && !guest_access |=> eff_two_stage && eff_priv == PRIV_U)
    else $error("virtual user not two-stage");
  chk_guest_access_mode: assert property (
    guest_access |=> eff_virt && eff_priv == ($past(hstatus_reg[B_HYP_GUEST_PRIV_BIT]) ? PRIV_S : PRIV_U))
    else $error("guest access regime wrong");
  chk_deleg_forced: assert property (
    reg_re && reg_addr == A_MDELEG |=>
      (reg_rdata[IRQW-1:0] & (DELEG_FORCED | DELEG_SGEI)) == (DELEG_FORCED | DELEG_SGEI))
    else $error("forced delegation bit clear");
  chk_hyp_view_zero: assert property (
    reg_re && (reg_addr == A_HIP || reg_addr == A_HIE || reg_addr == A_HDELEG) |=>
      (reg_rdata[IRQW-1:0] & ~$past(deleg_rd)) == IRQ_RESET)
    else $error("undelegated bit visible");
  chk_gpf_addr_shift: assert property (
    trap_take && trap_gpf && trap_gpa_valid |=> tval2_reg == ($past(trap_gpa) >> 2))
    else $error("guest address not recorded");
  chk_other_trap_zero: assert property (
    trap_take && !trap_gpf |=> tval2_reg == WORD_RESET && tinst_reg == $past(trap_instr))
    else $error("second trap value not cleared");
  chk_trap_saves_virt: assert property (
    trap_take |=> prev_virt_mode_bit == $past(virt_reg) && priv_reg == PRIV_M && !virt_reg)
    else $error("trap did not save virtualization");
  chk_ret_machine_virt: assert property (
    ret_take && !trap_take && prev_priv_field == PRIV_M |=> !virt_reg ##1 !virt_reg || $changed(priv_reg))
    else $error("return into machine set virtualization");

  cov_gpf_trap: cover property (trap_take && trap_gpf && trap_gpa_valid);
  cov_ret_virt: cover property (ret_take && prev_virt_mode_bit && prev_priv_field == PRIV_S ##1 virt_reg);
  cov_modify_privilege_bit_vs: cover property (modify_privilege_bit && prev_virt_mode_bit && prev_priv_field == PRIV_S ##1 eff_two_stage);
  cov_guest_access: cover property (guest_access ##1 eff_virt);

endmodule // hmtc_trap_csr
